// [bench/pad_model.sv]
// ==========================================
// Pad cells with drivers and weak pullups
module pad_model
    import pad_ctrl_pkg::*;
(
    input  wire logic                   clk,
    input  wire pad_ctrl_pkg::pad_ctrl_s pad,
    output logic [5:0]                   level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [5:0] float_pat;

    initial float_pat = 6'h15;
    // Unheld pins wander so no stale level passes
    always @(posedge clk) float_pat <= ~float_pat;

    // Driver beats pullup, pullup beats float
    assign level = (pad.drive_en & pad.drive_val)
                 | (~pad.drive_en & pad.pullup_on)
                 | (~pad.drive_en & ~pad.pullup_on & float_pat);
endmodule // pad_model

// [bench/tb_top.sv]
`include "pad_ctrl_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pad_ctrl_pkg::*;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    apb_req_s    req = '0;
    apb_rsp_s    rsp;
    logic [5:0]  pin_lvl;
    logic [5:0]  dig_oe = 6'h00;
    logic [5:0]  dig_out = 6'h00;
    pad_ctrl_s   pad;
    int          err_count = 0;
    int          checks_done = 0;

    always #5 clk = ~clk;

    port_pin_pad_control dut (
        .CLK(clk), .SRST(srst), .APB_REQ(req), .APB_RSP(rsp),
        .PIN_IN(pin_lvl), .DIGITAL_OE(dig_oe), .DIGITAL_OUT(dig_out),
        .PAD(pad)
    );
    pad_model pads (.clk(clk), .pad(pad), .level(pin_lvl));

    // ==========================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        r = rsp.prdata;
        e = rsp.pslverr;
        if (n >= 50) check("pready", 1'b0, 1'b1);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // Idle edge: the next call must not re-drive psel in this step
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check("prdata", r, exp);
        check("pslverr", {31'h0, e}, {31'h0, exp_err});
    endtask

    // Two synchroniser edges, so pin levels reach pin_sync2 (wr has already registered PAD)
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        rd(`OFS_PIN_PULLUP_ENABLE, 32'h0, 1'b0);
        rd(`OFS_PIN_SLEW_LIMIT, 32'h0, 1'b0);
        rd(`OFS_PIN_DRIVE_STRENGTH, 32'h0, 1'b0);
        check("pad", {2'h0, pad}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_regs();
        logic [11:0] ofs [3];
        ofs = '{`OFS_PIN_PULLUP_ENABLE, `OFS_PIN_SLEW_LIMIT,
                `OFS_PIN_DRIVE_STRENGTH};
        foreach (ofs[i]) begin
            wr(ofs[i], 32'hFFFF_FFFF);
            rd(ofs[i], 32'h0000_003F, 1'b0);
            wr(ofs[i], 32'h0000_002A);
            rd(ofs[i], 32'h0000_002A, 1'b0);
        end
        wr(12'h020, 32'h0000_0011);
        rd(12'h020, 32'h0, 1'b1);
        rd(ofs[0], 32'h0000_002A, 1'b0);
        $display("test registers done");
    endtask

    task automatic t_pullup();
        wr(`OFS_PIN_DIRECTION, 32'h0);
        wr(`OFS_PIN_PULLUP_ENABLE, 32'h3F);
        settle();
        check("pullup", pad.pullup_on, 6'h2F);
        check("level", pin_lvl[3:0], 4'hF);
        rd(`OFS_PIN_DATA, 32'h0000_002F, 1'b0);
        wr(`OFS_PIN_PULLUP_ENABLE, 32'h3A);
        settle();
        check("pullup", pad.pullup_on, 6'h2A);
        wr(`OFS_PIN_PULLUP_ENABLE, 32'h3F);
        wr(`OFS_PIN_DIRECTION, 32'h0F);
        settle();
        check("pullup", pad.pullup_on, 6'h20);
        check("drive_en", pad.drive_en[3:0], 4'hF);
        rd(`OFS_PIN_STATUS, 32'h0000_000F, 1'b0);
        $display("test pullup done");
    endtask

    task automatic t_slew_drive();
        wr(`OFS_PIN_SLEW_LIMIT, 32'h3F);
        wr(`OFS_PIN_DRIVE_STRENGTH, 32'h3F);
        wr(`OFS_PIN_DIRECTION, 32'h03);
        settle();
        check("slew", pad.slew_on & 6'h2F, 6'h03);
        check("drive", pad.high_drive & 6'h2F, 6'h03);
        wr(`OFS_PIN_SLEW_LIMIT, 32'h3E);
        wr(`OFS_PIN_DRIVE_STRENGTH, 32'h3D);
        settle();
        check("slew", pad.slew_on[1:0], 2'h2);
        check("drive", pad.high_drive[1:0], 2'h1);
        $display("test slew and drive done");
    endtask

    task automatic t_shared();
        wr(`OFS_PIN_DIRECTION, 32'h0A);
        wr(`OFS_PIN_PULLUP_ENABLE, 32'h3F);
        dig_oe <= 6'h01;
        dig_out <= 6'h01;
        wr(`OFS_PIN_FUNC_OWNER, 32'h0000_0007);
        settle();
        check("drive_en", pad.drive_en[3:0], 4'h9);
        check("drive_val", pad.drive_val[0], 1'b1);
        check("pullup", pad.pullup_on[3:0], 4'h6);
        wr(`OFS_PIN_FUNC_OWNER, 32'h0000_0903);
        rd(`OFS_PIN_FUNC_OWNER, 32'h0000_0903, 1'b0);
        settle();
        check("drive_en", pad.drive_en[3:0], 4'h0);
        check("pullup", pad.pullup_on[3:0], 4'h6);
        wr(`OFS_PIN_FUNC_OWNER, 32'h0);
        dig_oe <= 6'h00;
        $display("test shared and analog done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #100us;
        err_count++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_regs();
        t_pullup();
        t_slew_drive();
        t_shared();
        stop_test();
    end
endmodule // tb_top

// [design/pad_ctrl_params.svh]
`ifndef PAD_CTRL_PARAMS_SVH
`define PAD_CTRL_PARAMS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_PIN_DATA            12'h000
`define OFS_PIN_DIRECTION       12'h004
`define OFS_PIN_PULLUP_ENABLE   12'h008
`define OFS_PIN_SLEW_LIMIT      12'h00C
`define OFS_PIN_DRIVE_STRENGTH  12'h010
`define OFS_PIN_FUNC_OWNER      12'h014
`define OFS_PIN_STATUS          12'h018

// ==========================================================================
// Field layout and reset values
`define PIN_COUNT               6
`define OUTPUT_ONLY_IDX         4
`define INPUT_ONLY_IDX          5
`define CTRL_RESET              6'h00
`define DIGITAL_OWNER_LSB       0
`define ANALOG_OWNER_LSB        8

`endif

// [design/pad_ctrl_pkg.sv]
package pad_ctrl_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    typedef struct packed {
        logic [5:0] pullup_on;
        logic [5:0] slew_on;
        logic [5:0] high_drive;
        logic [5:0] drive_en;
        logic [5:0] drive_val;
    } pad_ctrl_s;

    typedef enum logic [1:0] {
        PIN_INPUT   = 2'b00,
        PIN_PORTOUT = 2'b01,
        PIN_SHARED  = 2'b11,
        PIN_ANALOG  = 2'b10
    } pin_mode_e;

endpackage

// [design/pad_pin_gate.sv]
`include "pad_ctrl_params.svh"

module pad_pin_gate #(
    parameter bit CAN_OUT = 1'b1,
    parameter bit CAN_IN  = 1'b1
) (
    input  wire logic                  direction,
    input  wire logic                  data_bit,
    input  wire logic                  pullup_bit,
    input  wire logic                  slew_bit,
    input  wire logic                  drive_bit,
    input  wire logic                  digital_own,
    input  wire logic                  digital_oe,
    input  wire logic                  digital_out,
    input  wire logic                  analog_own,
    output pad_ctrl_pkg::pin_mode_e    mode,
    output logic                       pullup_on,
    output logic                       slew_on,
    output logic                       high_drive,
    output logic                       drive_en,
    output logic                       drive_val
);
    import pad_ctrl_pkg::*;

    wire logic port_out;
    wire logic shared_out;
    wire logic is_out;

    // Analog wins over digital, digital owns the buffer over port direction
    assign mode = analog_own  ? PIN_ANALOG :
                  digital_own ? PIN_SHARED :
                  direction   ? PIN_PORTOUT : PIN_INPUT;
    assign port_out   = (mode == PIN_PORTOUT) && CAN_OUT;
    assign shared_out = (mode == PIN_SHARED) && digital_oe && CAN_OUT;
    assign is_out     = port_out || shared_out;
    assign drive_en   = is_out;
    assign drive_val  = shared_out ? digital_out : data_bit;
    // Output-only pin never gets a pullup
    assign pullup_on  = CAN_IN && !is_out && (mode != PIN_ANALOG)
                        && pullup_bit;
    // Input-only pin has no driver, so slew and drive are moot
    assign slew_on    = is_out && slew_bit;
    assign high_drive = is_out && drive_bit;

endmodule // pad_pin_gate

// [design/port_pin_pad_control.sv]
`include "pad_ctrl_params.svh"

module port_pin_pad_control (
    input  wire logic                   CLK,
    input  wire logic                   SRST,
    input  wire pad_ctrl_pkg::apb_req_s APB_REQ,
    output pad_ctrl_pkg::apb_rsp_s      APB_RSP,
    input  wire logic [5:0]             PIN_IN,
    input  wire logic [5:0]             DIGITAL_OE,
    input  wire logic [5:0]             DIGITAL_OUT,
    output pad_ctrl_pkg::pad_ctrl_s     PAD
);
    import pad_ctrl_pkg::*;

    // ======================================================================
    // Registers
    logic [5:0] pin_data;
    logic [5:0] pin_direction;
    logic [5:0] pin_pullup_enable;
    logic [5:0] pin_slew_limit_enable;
    logic [5:0] pin_drive_strength_select;
    logic [5:0] digital_owner;
    logic [5:0] analog_owner;
    logic [5:0] pin_sync1;
    logic [5:0] pin_sync2;
    logic [31:0] rdata;
    pad_ctrl_s   pad_next;
    pin_mode_e   mode [6];

    // ======================================================================
    // APB decode
    wire logic        setup   = APB_REQ.psel && !APB_REQ.penable;
    wire logic        access  = APB_REQ.psel && APB_REQ.penable;
    wire logic        wr      = access && APB_REQ.pwrite;
    wire logic [11:0] a       = APB_REQ.paddr;
    wire logic        hit_dat = (a == `OFS_PIN_DATA);
    wire logic        hit_dir = (a == `OFS_PIN_DIRECTION);
    wire logic        hit_pue = (a == `OFS_PIN_PULLUP_ENABLE);
    wire logic        hit_sle = (a == `OFS_PIN_SLEW_LIMIT);
    wire logic        hit_drv = (a == `OFS_PIN_DRIVE_STRENGTH);
    wire logic        hit_own = (a == `OFS_PIN_FUNC_OWNER);
    wire logic        hit_sts = (a == `OFS_PIN_STATUS);
    wire logic        mapped  = hit_dat || hit_dir || hit_pue || hit_sle
                                || hit_drv || hit_own || hit_sts;
    wire logic [5:0]  wd6     = APB_REQ.pwdata[5:0];
    // Input-only pin reads the pin; output-only pin reads the latch
    wire logic [5:0]  dir_eff = {1'b0, 1'b1, pin_direction[3:0]};
    wire logic [5:0]  in_ok   = ~analog_owner & 6'h2F;
    wire logic [5:0]  data_rd = (dir_eff & pin_data)
                                | (~dir_eff & in_ok & pin_sync2);
    wire logic [31:0] rd_mux  =
        hit_dat ? {26'h0, data_rd} :
        hit_dir ? {26'h0, 1'b0, pin_direction[4:0]} :
        hit_pue ? {26'h0, pin_pullup_enable} :
        hit_sle ? {26'h0, pin_slew_limit_enable} :
        hit_drv ? {26'h0, pin_drive_strength_select} :
        hit_own ? {18'h0, analog_owner, 2'h0, digital_owner} :
        hit_sts ? {26'h0, PAD.drive_en} : 32'h0;

    // Single-wait-free slave: every access finishes in its first cycle
    assign APB_RSP.pready  = 1'b1;
    assign APB_RSP.pslverr = access && !mapped;
    assign APB_RSP.prdata  = rdata;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_data                  <= `CTRL_RESET;
            pin_direction             <= `CTRL_RESET;
            pin_pullup_enable         <= `CTRL_RESET;
            pin_slew_limit_enable     <= `CTRL_RESET;
            pin_drive_strength_select <= `CTRL_RESET;
            digital_owner             <= `CTRL_RESET;
            analog_owner              <= `CTRL_RESET;
        end else if (wr) begin
            if (hit_dat) pin_data <= wd6;
            if (hit_dir) pin_direction <= wd6;
            if (hit_pue) pin_pullup_enable <= wd6;
            if (hit_sle) pin_slew_limit_enable <= wd6;
            if (hit_drv) pin_drive_strength_select <= wd6;
            if (hit_own) begin
                digital_owner <= APB_REQ.pwdata[5:0];
                analog_owner  <= APB_REQ.pwdata[13:8];
            end
        end
    end

    // Read data captured in setup so it is stable through the access phase
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rdata <= 32'h0;
        end else if (setup && !APB_REQ.pwrite) begin
            rdata <= rd_mux;
        end
    end

    // ======================================================================
    // Pin input synchroniser
    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_sync1 <= 6'h00;
            pin_sync2 <= 6'h00;
        end else begin
            pin_sync1 <= PIN_IN;
            pin_sync2 <= pin_sync1;
        end
    end

    // ======================================================================
    // Per-pin gating
    genvar g;
    generate
        for (g = 0; g < `PIN_COUNT; g++) begin : g_pin
            pad_pin_gate #(
                .CAN_OUT (g != `INPUT_ONLY_IDX),
                .CAN_IN  (g != `OUTPUT_ONLY_IDX)
            ) u_gate (
                .direction   (pin_direction[g]),
                .data_bit    (pin_data[g]),
                .pullup_bit  (pin_pullup_enable[g]),
                .slew_bit    (pin_slew_limit_enable[g]),
                .drive_bit   (pin_drive_strength_select[g]),
                .digital_own (digital_owner[g]),
                .digital_oe  (DIGITAL_OE[g]),
                .digital_out (DIGITAL_OUT[g]),
                .analog_own  (analog_owner[g]),
                .mode        (mode[g]),
                .pullup_on   (pad_next.pullup_on[g]),
                .slew_on     (pad_next.slew_on[g]),
                .high_drive  (pad_next.high_drive[g]),
                .drive_en    (pad_next.drive_en[g]),
                .drive_val   (pad_next.drive_val[g])
            );
        end
    endgenerate

    // Registered pad controls: one cycle after the cause
    always_ff @(posedge CLK) begin
        if (SRST) begin
            PAD <= '0;
        end else begin
            PAD <= pad_next;
        end
    end

    // ======================================================================
    // Assertions
    property p_pullup_off_out;
        @(posedge CLK) disable iff (SRST)
        pad_next.drive_en != 6'h00 |=> (PAD.pullup_on & PAD.drive_en) == 6'h0;
    endproperty
    a_pullup_off_out: assert property (p_pullup_off_out)
        else $error("pullup on while driving");

    property p_pullup_analog;
        @(posedge CLK) disable iff (SRST)
        analog_owner[0] |=> !PAD.pullup_on[0];
    endproperty
    a_pullup_analog: assert property (p_pullup_analog)
        else $error("pullup on analog pin");

    property p_pullup_follow;
        @(posedge CLK) disable iff (SRST)
        !pin_direction[0] && !digital_owner[0] && !analog_owner[0]
        |=> PAD.pullup_on[0] == $past(pin_pullup_enable[0]);
    endproperty
    a_pullup_follow: assert property (p_pullup_follow)
        else $error("pullup not following enable");

    property p_pin4_no_pullup;
        @(posedge CLK) disable iff (SRST) !PAD.pullup_on[4];
    endproperty
    a_pin4_no_pullup: assert property (p_pin4_no_pullup)
        else $error("pullup on output-only pin");

    property p_pin5_passive;
        @(posedge CLK) disable iff (SRST)
        !PAD.slew_on[5] && !PAD.high_drive[5] && !PAD.drive_en[5];
    endproperty
    a_pin5_passive: assert property (p_pin5_passive)
        else $error("input-only pin driven");

    property p_input_no_slew;
        @(posedge CLK) disable iff (SRST)
        (PAD.drive_en | ~(PAD.slew_on | PAD.high_drive)) == 6'h3F;
    endproperty
    a_input_no_slew: assert property (p_input_no_slew)
        else $error("slew or drive on input");

    property p_slew_drive;
        @(posedge CLK) disable iff (SRST)
        pin_direction[1] && !digital_owner[1] && !analog_owner[1]
        |=> PAD.drive_en[1]
            && PAD.slew_on[1] == $past(pin_slew_limit_enable[1])
            && PAD.high_drive[1] == $past(pin_drive_strength_select[1]);
    endproperty
    a_slew_drive: assert property (p_slew_drive)
        else $error("slew or drive not applied");

    property p_shared_owns;
        @(posedge CLK) disable iff (SRST)
        digital_owner[2] && !analog_owner[2] && !DIGITAL_OE[2]
        |=> !PAD.drive_en[2];
    endproperty
    a_shared_owns: assert property (p_shared_owns)
        else $error("port drives shared pin");

    property p_analog_wins;
        @(posedge CLK) disable iff (SRST)
        analog_owner[3] |=> !PAD.drive_en[3];
    endproperty
    a_analog_wins: assert property (p_analog_wins)
        else $error("analog pin driven");

    property p_readback;
        @(posedge CLK) disable iff (SRST)
        setup && !APB_REQ.pwrite && hit_pue
        |=> rdata == {26'h0, $past(pin_pullup_enable)};
    endproperty
    a_readback: assert property (p_readback)
        else $error("readback mismatch");

    // Edge of reset release only, so the unreset first cycles stay quiet
    property p_reset_clear;
        @(posedge CLK)
        $fell(SRST) |-> pin_pullup_enable == 6'h00
            && pin_slew_limit_enable == 6'h00
            && pin_drive_strength_select == 6'h00 && PAD == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("controls not clear after reset");

    property p_pready_one;
        @(posedge CLK) disable iff (SRST) access |-> APB_RSP.pready;
    endproperty
    a_pready_one: assert property (p_pready_one)
        else $error("access not answered");

    property p_slverr_map;
        @(posedge CLK) disable iff (SRST)
        access |-> APB_RSP.pslverr == !mapped;
    endproperty
    a_slverr_map: assert property (p_slverr_map)
        else $error("error response wrong");

    property p_pue_write;
        @(posedge CLK) disable iff (SRST)
        wr && hit_pue |=> pin_pullup_enable == $past(APB_REQ.pwdata[5:0]);
    endproperty
    a_pue_write: assert property (p_pue_write)
        else $error("pullup enable write lost");

    property p_sle_write;
        @(posedge CLK) disable iff (SRST)
        wr && hit_sle
        |=> pin_slew_limit_enable == $past(APB_REQ.pwdata[5:0]);
    endproperty
    a_sle_write: assert property (p_sle_write)
        else $error("slew enable write lost");

    property p_drv_write;
        @(posedge CLK) disable iff (SRST)
        wr && hit_drv
        |=> pin_drive_strength_select == $past(APB_REQ.pwdata[5:0]);
    endproperty
    a_drv_write: assert property (p_drv_write)
        else $error("drive select write lost");

    property p_pin5_pullup;
        @(posedge CLK) disable iff (SRST)
        !analog_owner[5]
        |=> PAD.pullup_on[5] == $past(pin_pullup_enable[5]);
    endproperty
    a_pin5_pullup: assert property (p_pin5_pullup)
        else $error("input-only pin pullup wrong");

    property p_shared_drive;
        @(posedge CLK) disable iff (SRST)
        digital_owner[0] && !analog_owner[0]
        |=> PAD.drive_en[0] == $past(DIGITAL_OE[0])
            && (!PAD.drive_en[0]
                || PAD.drive_val[0] == $past(DIGITAL_OUT[0]));
    endproperty
    a_shared_drive: assert property (p_shared_drive)
        else $error("shared function not driving pin");

    property p_port_drive_val;
        @(posedge CLK) disable iff (SRST)
        pin_direction[1] && !digital_owner[1] && !analog_owner[1]
        |=> PAD.drive_val[1] == $past(pin_data[1]);
    endproperty
    a_port_drive_val: assert property (p_port_drive_val)
        else $error("port output value wrong");

    property p_analog_no_pullup;
        @(posedge CLK) disable iff (SRST)
        (PAD.pullup_on & $past(analog_owner)) == 6'h00;
    endproperty
    a_analog_no_pullup: assert property (p_analog_no_pullup)
        else $error("pullup on analog pin");

    c_write: cover property (@(posedge CLK) wr && hit_pue);
    c_shared: cover property (@(posedge CLK) PAD.drive_en[0]
                              && digital_owner[0]);
    c_pullup: cover property (@(posedge CLK) PAD.pullup_on[1]);
    c_highdrv: cover property (@(posedge CLK) PAD.high_drive[2]);
    c_analog: cover property (@(posedge CLK) mode[0] == PIN_ANALOG);

endmodule // port_pin_pad_control
